// ---- rsse_pkg.sv ----
package rsse_pkg;

    // Operation select codes presented by the decode stage
    typedef enum logic [4:0] {
        RSSE_OP_NONE,
        RSSE_OP_EXIT_LOAD_IMM,
        RSSE_OP_IRQ_EXIT,
        RSSE_OP_ROTL,
        RSSE_OP_ROTL_W,
        RSSE_OP_ROTLC,
        RSSE_OP_ROTLC_W,
        RSSE_OP_ROTR,
        RSSE_OP_ROTR_W,
        RSSE_OP_ROTRC,
        RSSE_OP_ROTRC_W,
        RSSE_OP_SBC,
        RSSE_OP_SBC_MEM,
        RSSE_OP_SUB,
        RSSE_OP_SUB_IMM,
        RSSE_OP_SUB_MEM,
        RSSE_OP_DSZ,
        RSSE_OP_DSZ_W,
        RSSE_OP_ISZ,
        RSSE_OP_ISZ_W,
        RSSE_OP_SKIP_BIT,
        RSSE_OP_SET_BYTE,
        RSSE_OP_SET_BIT
    } rsse_op_t;

    localparam int          RSSE_DATA_W      = 8;
    localparam int          RSSE_MSB         = 7;
    localparam logic [7:0]  RSSE_ALL_ONES    = 8'hff;
    localparam logic [7:0]  RSSE_ONE         = 8'h01;
    localparam logic [7:0]  RSSE_W_RST       = 8'h00;
    localparam logic [3:0]  RSSE_FLAGS_RST   = 4'h0;
    localparam logic [7:0]  RSSE_PC_LOW_RST  = 8'h00;
    localparam logic        RSSE_IRQ_EN_RST  = 1'b0;

    // Flag vector bit positions
    localparam int          RSSE_FLAG_C      = 0;
    localparam int          RSSE_FLAG_HC     = 1;
    localparam int          RSSE_FLAG_Z      = 2;
    localparam int          RSSE_FLAG_OV     = 3;

endpackage

// ---- rsse_exec.sv ----
`timescale 1ns/100ps
module rsse_exec (
    // Clock, reset, enable
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic             clk_en_i,
    // Decoded instruction
    input  wire logic             op_valid_i,
    input  wire rsse_pkg::rsse_op_t op_i,
    input  wire logic [7:0]       mem_rd_data_i,
    input  wire logic [7:0]       imm_i,
    input  wire logic [2:0]       bit_sel_i,
    input  wire logic             irq_pending_i,
    // Data memory write
    output logic                  mem_wr_o,
    output logic [7:0]            mem_wr_data_o,
    // Core state
    output logic [7:0]            working_register_o,
    output logic                  carry_o,
    output logic                  half_carry_o,
    output logic                  zero_o,
    output logic                  signed_wrap_flag_o,
    output logic                  master_irq_enable_o,
    // Flow control
    output logic                  stack_pop_o,
    output logic                  skip_o,
    output logic                  busy_o,
    output logic                  irq_take_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef enum logic [1:0] {
        RSSE_ST_RUN,
        RSSE_ST_DUMMY
    } rsse_state_t;

    typedef struct packed {
        rsse_state_t  st;
        logic [7:0]   w;
        logic [3:0]   flags;
        logic         irq_en;
        // Registered pulses and data for the memory, stack, skip and interrupt ports
        logic         mem_wr;
        logic [7:0]   mem_data;
        logic         pop;
        logic         skip;
        logic         irq_take;
    } rsse_regs_t;

    // q is the registered state, d its next value
    rsse_regs_t q;
    rsse_regs_t d;

    // One-hot bit mask, shared by the bit test and bit set paths
    function automatic logic [7:0] rsse_bit_mask(input logic [2:0] sel);
        rsse_bit_mask = rsse_pkg::RSSE_ONE << sel;
    endfunction

    // Borrow forms feed the old carry into the subtractor
    function automatic logic rsse_uses_borrow(input rsse_pkg::rsse_op_t op);
        rsse_uses_borrow = (op == rsse_pkg::RSSE_OP_SBC) || (op == rsse_pkg::RSSE_OP_SBC_MEM);
    endfunction

    // Memory-destination subtract forms write back instead of loading W
    function automatic logic rsse_sub_to_mem(input rsse_pkg::rsse_op_t op);
        rsse_sub_to_mem = (op == rsse_pkg::RSSE_OP_SBC_MEM) || (op == rsse_pkg::RSSE_OP_SUB_MEM);
    endfunction

    // Zero test shared by the zero flag and every counting skip
    function automatic logic rsse_is_zero(input logic [7:0] v);
        rsse_is_zero = (v == 8'h00);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Subtractor shared by every subtract form

    logic [7:0] sub_rhs;
    logic       sub_cin;
    logic [8:0] sub_full;
    logic [4:0] sub_low;
    logic [7:0] sub_res;
    logic       sub_ov;

    // Subtraction as W + ~rhs + cin: carry out high means no borrow
    always_comb begin
        sub_rhs  = (op_i == rsse_pkg::RSSE_OP_SUB_IMM) ? imm_i : mem_rd_data_i;
        sub_cin  = rsse_uses_borrow(op_i) ? q.flags[rsse_pkg::RSSE_FLAG_C] : 1'b1;
        sub_full = {1'b0, q.w} + {1'b0, ~sub_rhs} + {8'h00, sub_cin};
        // Half carry is the carry out of the low nibble of the same sum
        sub_low  = {1'b0, q.w[3:0]} + {1'b0, ~sub_rhs[3:0]} + {4'h0, sub_cin};
        sub_res  = sub_full[7:0];
        // Signed wrap: operands of unlike sign and a result whose sign left W's
        sub_ov   = (q.w[7] != sub_rhs[7]) && (sub_res[7] != q.w[7]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Rotators and counters on the memory operand

    logic [7:0] opnd;
    logic       c_old;
    logic [7:0] rot_l;
    logic [7:0] rot_lc;
    logic [7:0] rot_r;
    logic [7:0] rot_rc;
    logic [7:0] dec_v;
    logic [7:0] inc_v;
    logic       take;

    // Every rotate and count reads memory; W-destination forms only redirect the result
    assign opnd  = mem_rd_data_i;
    assign c_old = q.flags[rsse_pkg::RSSE_FLAG_C];

    // Inner bits move up one place for both left rotates
    for (genvar i = 1; i < rsse_pkg::RSSE_DATA_W; i++) begin : g_rot_up
        assign rot_l[i]  = opnd[i-1];
        assign rot_lc[i] = opnd[i-1];
    end

    // Inner bits move down one place for both right rotates
    for (genvar i = 0; i < rsse_pkg::RSSE_MSB; i++) begin : g_rot_dn
        assign rot_r[i]  = opnd[i+1];
        assign rot_rc[i] = opnd[i+1];
    end

    // End bits: plain rotates wrap, carry forms take the carry held before this op
    assign rot_l[0]                   = opnd[rsse_pkg::RSSE_MSB];
    assign rot_lc[0]                  = c_old;
    assign rot_r[rsse_pkg::RSSE_MSB]  = opnd[0];
    assign rot_rc[rsse_pkg::RSSE_MSB] = c_old;

    // Counters wrap modulo 256, so FF plus one and 01 minus one both land on zero
    assign dec_v = opnd - rsse_pkg::RSSE_ONE;
    assign inc_v = opnd + rsse_pkg::RSSE_ONE;

    // An op is only taken in the run state; during the dummy slot it is dropped
    assign take  = op_valid_i && (q.st == RSSE_ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d          = q;
        // Pulses last one cycle unless an op raises them again
        d.mem_wr   = 1'b0;
        d.pop      = 1'b0;
        d.skip     = 1'b0;
        d.irq_take = 1'b0;
        // Run state decodes one op; the dummy slot comes only after a taken skip
        case (q.st)
            // Dummy slot while the skipped instruction is discarded
            RSSE_ST_DUMMY: begin
                d.st = RSSE_ST_RUN;
            end
            RSSE_ST_RUN: begin
                if (take) begin
                    // Single-cycle data operations unless a skip is taken
                    case (op_i)
                        // Return with a constant for the caller
                        rsse_pkg::RSSE_OP_EXIT_LOAD_IMM: begin
                            d.pop = 1'b1;
                            d.w   = imm_i;
                        end
                        // Fetch stage vectors to a pending request before resuming
                        rsse_pkg::RSSE_OP_IRQ_EXIT: begin
                            d.pop      = 1'b1;
                            d.irq_en   = 1'b1;
                            d.irq_take = irq_pending_i;
                        end
                        // Plain left rotate back to memory
                        rsse_pkg::RSSE_OP_ROTL: begin
                            d.mem_wr   = 1'b1;
                            d.mem_data = rot_l;
                        end
                        // Plain left rotate into W, memory kept
                        rsse_pkg::RSSE_OP_ROTL_W: begin
                            d.w = rot_l;
                        end
                        // Left through carry back to memory
                        rsse_pkg::RSSE_OP_ROTLC: begin
                            d.mem_wr   = 1'b1;
                            d.mem_data = rot_lc;
                            d.flags[rsse_pkg::RSSE_FLAG_C] = opnd[7];
                        end
                        // Left through carry into W
                        rsse_pkg::RSSE_OP_ROTLC_W: begin
                            d.w = rot_lc;
                            d.flags[rsse_pkg::RSSE_FLAG_C] = opnd[7];
                        end
                        // Plain right rotate back to memory
                        rsse_pkg::RSSE_OP_ROTR: begin
                            d.mem_wr   = 1'b1;
                            d.mem_data = rot_r;
                        end
                        // Plain right rotate into W, memory kept
                        rsse_pkg::RSSE_OP_ROTR_W: begin
                            d.w = rot_r;
                        end
                        // Right through carry back to memory
                        rsse_pkg::RSSE_OP_ROTRC: begin
                            d.mem_wr   = 1'b1;
                            d.mem_data = rot_rc;
                            d.flags[rsse_pkg::RSSE_FLAG_C] = opnd[0];
                        end
                        // Right through carry into W
                        rsse_pkg::RSSE_OP_ROTRC_W: begin
                            d.w = rot_rc;
                            d.flags[rsse_pkg::RSSE_FLAG_C] = opnd[0];
                        end
                        // Every subtract form shares one adder and one flag update
                        rsse_pkg::RSSE_OP_SBC,
                        rsse_pkg::RSSE_OP_SUB,
                        rsse_pkg::RSSE_OP_SUB_IMM,
                        rsse_pkg::RSSE_OP_SBC_MEM,
                        rsse_pkg::RSSE_OP_SUB_MEM: begin
                            if (rsse_sub_to_mem(op_i)) begin
                                d.mem_wr   = 1'b1;
                                d.mem_data = sub_res;
                            end else begin
                                d.w = sub_res;
                            end
                            // Flags follow the same rule whether the result goes to W or memory
                            d.flags[rsse_pkg::RSSE_FLAG_C]  = sub_full[8];
                            d.flags[rsse_pkg::RSSE_FLAG_HC] = sub_low[4];
                            d.flags[rsse_pkg::RSSE_FLAG_Z]  = rsse_is_zero(sub_res);
                            d.flags[rsse_pkg::RSSE_FLAG_OV] = sub_ov;
                        end
                        // Count down in memory, skip on zero
                        rsse_pkg::RSSE_OP_DSZ: begin
                            d.mem_wr   = 1'b1;
                            d.mem_data = dec_v;
                            d.skip     = rsse_is_zero(dec_v);
                        end
                        // Count up in memory, skip on zero
                        rsse_pkg::RSSE_OP_ISZ: begin
                            d.mem_wr   = 1'b1;
                            d.mem_data = inc_v;
                            d.skip     = rsse_is_zero(inc_v);
                        end
                        // Count down into W, memory kept
                        rsse_pkg::RSSE_OP_DSZ_W: begin
                            d.w    = dec_v;
                            d.skip = rsse_is_zero(dec_v);
                        end
                        // Count up into W, memory kept
                        rsse_pkg::RSSE_OP_ISZ_W: begin
                            d.w    = inc_v;
                            d.skip = rsse_is_zero(inc_v);
                        end
                        // Bit test only; nothing is written
                        rsse_pkg::RSSE_OP_SKIP_BIT: begin
                            d.skip = |(opnd & rsse_bit_mask(bit_sel_i));
                        end
                        // Whole byte to ones
                        rsse_pkg::RSSE_OP_SET_BYTE: begin
                            d.mem_wr   = 1'b1;
                            d.mem_data = rsse_pkg::RSSE_ALL_ONES;
                        end
                        // Read-modify-write of one bit
                        rsse_pkg::RSSE_OP_SET_BIT: begin
                            d.mem_wr   = 1'b1;
                            d.mem_data = opnd | rsse_bit_mask(bit_sel_i);
                        end
                        // No-op and unused codes change nothing
                        default: begin
                        end
                    endcase
                    // A taken skip costs a second, dummy cycle
                    if (d.skip) begin
                        d.st = RSSE_ST_DUMMY;
                    end
                end
            end
            default: begin
                d.st = RSSE_ST_RUN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers; clock enable low freezes everything

    always_ff @(posedge sys_clk_i) begin
        // Reset wins over the enable so it works with the clock held off
        if (rst_i) begin
            q.st       <= RSSE_ST_RUN;
            q.w        <= rsse_pkg::RSSE_W_RST;
            q.flags    <= rsse_pkg::RSSE_FLAGS_RST;
            q.irq_en   <= rsse_pkg::RSSE_IRQ_EN_RST;
            q.mem_wr   <= 1'b0;
            q.mem_data <= rsse_pkg::RSSE_W_RST;
            q.pop      <= 1'b0;
            q.skip     <= 1'b0;
            q.irq_take <= 1'b0;
        end else if (clk_en_i) begin
            // Whole state moves together so no field can lag another
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Memory write port
    assign mem_wr_o            = q.mem_wr;
    assign mem_wr_data_o       = q.mem_data;
    // Core state
    assign working_register_o  = q.w;
    assign carry_o             = q.flags[rsse_pkg::RSSE_FLAG_C];
    assign half_carry_o        = q.flags[rsse_pkg::RSSE_FLAG_HC];
    assign zero_o              = q.flags[rsse_pkg::RSSE_FLAG_Z];
    assign signed_wrap_flag_o  = q.flags[rsse_pkg::RSSE_FLAG_OV];
    assign master_irq_enable_o = q.irq_en;
    // Flow pulses
    assign stack_pop_o         = q.pop;
    assign skip_o              = q.skip;
    assign irq_take_o          = q.irq_take;
    // Decode must hold off while the dummy slot runs
    assign busy_o              = (q.st == RSSE_ST_DUMMY);

endmodule

// ---- rsse_exec_properties.sv ----
`timescale 1ns/100ps
module rsse_exec_properties (
    // Clock and reset
    input wire logic               sys_clk_i,
    input wire logic               rst_i,
    // Design inputs
    input wire logic               clk_en_i,
    input wire logic               op_valid_i,
    input wire rsse_pkg::rsse_op_t op_i,
    input wire logic [7:0]         mem_rd_data_i,
    input wire logic [7:0]         imm_i,
    input wire logic [2:0]         bit_sel_i,
    input wire logic               irq_pending_i,
    // Design outputs
    input wire logic               mem_wr_o,
    input wire logic [7:0]         mem_wr_data_o,
    input wire logic [7:0]         working_register_o,
    input wire logic               carry_o,
    input wire logic               half_carry_o,
    input wire logic               zero_o,
    input wire logic               signed_wrap_flag_o,
    input wire logic               master_irq_enable_o,
    input wire logic               stack_pop_o,
    input wire logic               skip_o,
    input wire logic               busy_o,
    input wire logic               irq_take_o
);
    // Taken op, flag vector and reference arithmetic
    logic       tk;
    logic [3:0] fl;
    logic [7:0] dif;
    logic [7:0] dec;
    assign tk  = clk_en_i && op_valid_i && !busy_o;
    assign fl  = {signed_wrap_flag_o, zero_o, half_carry_o, carry_o};
    assign dif = working_register_o - mem_rd_data_i;
    assign dec = mem_rd_data_i - 8'h01;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////////
    // Each check except dummy_cycle_a ties the registered answer to the op taken one edge earlier
    byte_set_a: assert property (tk && op_i == rsse_pkg::RSSE_OP_SET_BYTE |=>
        mem_wr_o && mem_wr_data_o == 8'hff && fl == $past(fl)) else $error("byte set wrong");
    bit_set_a: assert property (tk && op_i == rsse_pkg::RSSE_OP_SET_BIT |=>
        mem_wr_o && mem_wr_data_o == ($past(mem_rd_data_i) | (8'h01 << $past(bit_sel_i)))) else $error("bit set wrong");
    rot_left_a: assert property (tk && op_i == rsse_pkg::RSSE_OP_ROTL |=> mem_wr_o && fl == $past(fl) &&
        mem_wr_data_o == {$past(mem_rd_data_i[6:0]), $past(mem_rd_data_i[7])}) else $error("rotate left wrong");
    rot_right_carry_a: assert property (tk && op_i == rsse_pkg::RSSE_OP_ROTRC_W |=> !mem_wr_o &&
        working_register_o == {$past(carry_o), $past(mem_rd_data_i[7:1])} && carry_o == $past(mem_rd_data_i[0]))
        else $error("rotate right via carry wrong");
    exit_imm_a: assert property (tk && op_i == rsse_pkg::RSSE_OP_EXIT_LOAD_IMM |=> stack_pop_o &&
        working_register_o == $past(imm_i) && fl == $past(fl)) else $error("exit with immediate wrong");
    irq_exit_a: assert property (tk && op_i == rsse_pkg::RSSE_OP_IRQ_EXIT |=>
        stack_pop_o && master_irq_enable_o && irq_take_o == $past(irq_pending_i) && fl == $past(fl))
        else $error("interrupt exit wrong");
    sub_result_a: assert property (tk && op_i == rsse_pkg::RSSE_OP_SUB |=>
        working_register_o == $past(dif) && carry_o == ($past(working_register_o) >= $past(mem_rd_data_i)))
        else $error("subtract wrong");
    decr_skip_a: assert property (tk && op_i == rsse_pkg::RSSE_OP_DSZ |=> mem_wr_o && fl == $past(fl) &&
        mem_wr_data_o == $past(dec) && skip_o == ($past(dec) == 8'h00)) else $error("decrement skip wrong");
    dummy_cycle_a: assert property (skip_o |-> busy_o ##1 (!busy_o && !skip_o && !mem_wr_o))
        else $error("dummy cycle wrong");

    // Main scenarios reached
    cover property (tk && op_i == rsse_pkg::RSSE_OP_DSZ ##1 skip_o);
    cover property (irq_take_o);
    cover property (busy_o && op_valid_i);
endmodule

bind rsse_exec rsse_exec_properties u_props (.sys_clk_i, .rst_i, .clk_en_i, .op_valid_i, .op_i, .mem_rd_data_i,
    .imm_i, .bit_sel_i, .irq_pending_i, .mem_wr_o, .mem_wr_data_o, .working_register_o, .carry_o, .half_carry_o,
    .zero_o, .signed_wrap_flag_o, .master_irq_enable_o, .stack_pop_o, .skip_o, .busy_o, .irq_take_o);

// ---- rsse_exec_tb.sv ----
`timescale 1ns/100ps
module rsse_exec_tb;
    // Row: op, operand byte (memory and immediate), bit, then W, {OV,Z,HC,C}, {write,data}, skip
    typedef struct {
        rsse_pkg::rsse_op_t op;
        logic [7:0]         arg;
        logic [2:0]         bs;
        logic [7:0]         w;
        logic [3:0]         f;
        logic [8:0]         wd;
        logic               sk;
    } rsse_row_t;

    logic               sys_clk_i, rst_i, clk_en_i, op_valid_i, irq_pending_i;
    rsse_pkg::rsse_op_t op_i;
    logic [7:0]         mem_rd_data_i, imm_i, mem_wr_data_o, working_register_o;
    logic [2:0]         bit_sel_i;
    logic               mem_wr_o, carry_o, half_carry_o, zero_o, signed_wrap_flag_o;
    logic               master_irq_enable_o, stack_pop_o, skip_o, busy_o, irq_take_o;
    logic [7:0]         flg;
    int                 mismatches, comparisons;
    assign flg = {4'h0, signed_wrap_flag_o, zero_o, half_carry_o, carry_o};

    // Rows run in order, so each one starts from the state the previous row left
    rsse_row_t rows [24] = '{
        '{rsse_pkg::RSSE_OP_EXIT_LOAD_IMM, 8'h05, 3'h0, 8'h05, 4'h0, 9'h000, 1'b0},
        '{rsse_pkg::RSSE_OP_SUB, 8'h07, 3'h0, 8'hfe, 4'h0, 9'h000, 1'b0},
        '{rsse_pkg::RSSE_OP_SUB_IMM, 8'h80, 3'h0, 8'h7e, 4'h3, 9'h000, 1'b0},
        '{rsse_pkg::RSSE_OP_SUB, 8'h80, 3'h0, 8'hfe, 4'ha, 9'h000, 1'b0},
        '{rsse_pkg::RSSE_OP_SBC, 8'hfd, 3'h0, 8'h00, 4'h7, 9'h000, 1'b0},
        '{rsse_pkg::RSSE_OP_SBC_MEM, 8'h01, 3'h0, 8'h00, 4'h0, 9'h1ff, 1'b0},
        '{rsse_pkg::RSSE_OP_SUB_MEM, 8'h00, 3'h0, 8'h00, 4'h7, 9'h100, 1'b0},
        '{rsse_pkg::RSSE_OP_ROTLC, 8'h80, 3'h0, 8'h00, 4'h7, 9'h101, 1'b0},
        '{rsse_pkg::RSSE_OP_ROTLC_W, 8'h01, 3'h0, 8'h03, 4'h6, 9'h000, 1'b0},
        '{rsse_pkg::RSSE_OP_ROTRC, 8'h01, 3'h0, 8'h03, 4'h7, 9'h100, 1'b0},
        '{rsse_pkg::RSSE_OP_ROTRC_W, 8'h02, 3'h0, 8'h81, 4'h6, 9'h000, 1'b0},
        '{rsse_pkg::RSSE_OP_ROTL, 8'h81, 3'h0, 8'h81, 4'h6, 9'h103, 1'b0},
        '{rsse_pkg::RSSE_OP_ROTL_W, 8'h81, 3'h0, 8'h03, 4'h6, 9'h000, 1'b0},
        '{rsse_pkg::RSSE_OP_ROTR, 8'h01, 3'h0, 8'h03, 4'h6, 9'h180, 1'b0},
        '{rsse_pkg::RSSE_OP_ROTR_W, 8'h02, 3'h0, 8'h01, 4'h6, 9'h000, 1'b0},
        '{rsse_pkg::RSSE_OP_SET_BYTE, 8'h12, 3'h0, 8'h01, 4'h6, 9'h1ff, 1'b0},
        '{rsse_pkg::RSSE_OP_SET_BIT, 8'h00, 3'h5, 8'h01, 4'h6, 9'h120, 1'b0},
        '{rsse_pkg::RSSE_OP_DSZ, 8'h05, 3'h0, 8'h01, 4'h6, 9'h104, 1'b0},
        '{rsse_pkg::RSSE_OP_ISZ, 8'hff, 3'h0, 8'h01, 4'h6, 9'h100, 1'b1},
        '{rsse_pkg::RSSE_OP_DSZ_W, 8'h01, 3'h0, 8'h00, 4'h6, 9'h000, 1'b1},
        '{rsse_pkg::RSSE_OP_ISZ_W, 8'h05, 3'h0, 8'h06, 4'h6, 9'h000, 1'b0},
        '{rsse_pkg::RSSE_OP_SKIP_BIT, 8'h20, 3'h5, 8'h06, 4'h6, 9'h000, 1'b1},
        '{rsse_pkg::RSSE_OP_SKIP_BIT, 8'hdf, 3'h5, 8'h06, 4'h6, 9'h000, 1'b0},
        '{rsse_pkg::RSSE_OP_DSZ, 8'h01, 3'h0, 8'h06, 4'h6, 9'h100, 1'b1}};

    rsse_exec DUT (.sys_clk_i, .rst_i, .clk_en_i, .op_valid_i, .op_i, .mem_rd_data_i, .imm_i, .bit_sel_i,
        .irq_pending_i, .mem_wr_o, .mem_wr_data_o, .working_register_o, .carry_o, .half_carry_o, .zero_o,
        .signed_wrap_flag_o, .master_irq_enable_o, .stack_pop_o, .skip_o, .busy_o, .irq_take_o);

    // 20 MHz core clock
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Byte compare; bits go through it zero-extended
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    // Present an op at a falling edge; valid stays up so a following call is back to back
    task automatic op(input rsse_pkg::rsse_op_t o, input logic [7:0] a, input logic [2:0] b);
        op_valid_i = 1'b1;
        op_i = o;
        mem_rd_data_i = a;
        imm_i = a;
        bit_sel_i = b;
        @(negedge sys_clk_i);
    endtask

    task automatic idle;
        op_valid_i = 1'b0;
        @(negedge sys_clk_i);
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_i, clk_en_i, op_valid_i, irq_pending_i, mem_rd_data_i, imm_i, bit_sel_i} = {3'b110, 20'h0};
        op_i = rsse_pkg::RSSE_OP_NONE;
        repeat (20) @(negedge sys_clk_i);
        rst_i = 1'b0;
        // Table: one op, then an idle cycle that also covers the dummy cycle of a skip
        foreach (rows[i]) begin
            op(rows[i].op, rows[i].arg, rows[i].bs);
            chk8(working_register_o, rows[i].w);
            chk8(flg, {4'h0, rows[i].f});
            chk1(mem_wr_o, rows[i].wd[8]);
            if (rows[i].wd[8]) chk8(mem_wr_data_o, rows[i].wd[7:0]);
            chk1(skip_o, rows[i].sk);
            chk1(busy_o, rows[i].sk);
            idle();
            chk1(busy_o, 1'b0);
        end
        // Back to back, then an op offered during the dummy cycle is ignored
        op(rsse_pkg::RSSE_OP_EXIT_LOAD_IMM, 8'haa, 3'h0);
        chk1(stack_pop_o, 1'b1);
        op(rsse_pkg::RSSE_OP_SUB_IMM, 8'h0a, 3'h0);
        chk8(working_register_o, 8'ha0);
        op(rsse_pkg::RSSE_OP_DSZ, 8'h01, 3'h0);
        op(rsse_pkg::RSSE_OP_SUB_IMM, 8'h01, 3'h0);
        chk8(working_register_o, 8'ha0);
        op(rsse_pkg::RSSE_OP_SUB_IMM, 8'h01, 3'h0);
        chk8(working_register_o, 8'h9f);
        // Enable low freezes the block
        idle();
        clk_en_i = 1'b0;
        op(rsse_pkg::RSSE_OP_SET_BYTE, 8'h00, 3'h0);
        chk1(mem_wr_o, 1'b0);
        idle();
        clk_en_i = 1'b1;
        // Interrupt exit with and without a pending request
        irq_pending_i = 1'b1;
        op(rsse_pkg::RSSE_OP_IRQ_EXIT, 8'h00, 3'h0);
        chk1(stack_pop_o, 1'b1);
        chk1(master_irq_enable_o, 1'b1);
        chk1(irq_take_o, 1'b1);
        chk8(flg, 8'h01);
        irq_pending_i = 1'b0;
        op(rsse_pkg::RSSE_OP_IRQ_EXIT, 8'h00, 3'h0);
        chk1(irq_take_o, 1'b0);
        idle();
        // Reset in mid-run returns the core state to its reset values
        rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        chk8(working_register_o, rsse_pkg::RSSE_W_RST);
        chk8(flg, {4'h0, rsse_pkg::RSSE_FLAGS_RST});
        chk1(master_irq_enable_o, rsse_pkg::RSSE_IRQ_EN_RST);
        rst_i = 1'b0;
        wrap_up();
    end

    // Whole run is about 80 cycles, so 400 means a hang
    initial begin
        repeat (400) @(posedge sys_clk_i);
        mismatches++;
        wrap_up();
    end
endmodule
